// ==== common/cfg_pkg.sv ====
// Purpose: shared constants and types for the configuration pin logic
// Assumes: 50 MHz system clock
// Notes: mode codes are a local encoding
package cfg_pkg;
  localparam int CLK_HZ      = 50_000_000;
  localparam int OSC_FAST_HZ = 10_000_000;
  localparam int OSC_SLOW_HZ = 1_250_000;
  localparam int DIV_W       = 6;
  localparam logic [DIV_W-1:0] FAST_DIV = DIV_W'(CLK_HZ / OSC_FAST_HZ);
  localparam logic [DIV_W-1:0] SLOW_DIV = DIV_W'(CLK_HZ / OSC_SLOW_HZ);
  localparam int ADDR_W    = 18;
  localparam int DATA_W    = 8;
  localparam int CNT_W     = 16;
  localparam int DELAY_W   = 2;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    MODE_MASTER_SERIAL   = 3'h0,
    MODE_SLAVE_PARALLEL  = 3'h1,
    MODE_MASTER_PARALLEL = 3'h2,
    MODE_SYNC_PERIPH     = 3'h3,
    MODE_ASYNC_PERIPH    = 3'h4,
    MODE_RESERVED5       = 3'h5,
    MODE_RESERVED6       = 3'h6,
    MODE_SLAVE_SERIAL    = 3'h7
  } cfgMode_t;

  typedef enum logic [4:0] {
    ST_CLEAR   = 5'h01,
    ST_WAIT    = 5'h02,
    ST_LOAD    = 5'h04,
    ST_RELEASE = 5'h08,
    ST_USER    = 5'h10
  } cfgState_t;

  typedef struct packed {
    logic chipSelLowN;
    logic chipSelHigh;
    logic loadStrobeN;
    logic statusReadN;
  } hostCtl_t;

  typedef struct packed {
    logic               initLine;
    logic               programN;
    logic               cfgClock;
    logic               serialIn;
    hostCtl_t           host;
    logic               oscSpeedSel;
    logic [2:0]         modeSel;
    logic               scanSelect;
    logic [DELAY_W-1:0] doneDelay;
    logic [DELAY_W-1:0] pinDelay;
    logic               chainAck;
    logic [DATA_W-1:0]  data;
  } pinBundle_t;

  localparam int PIN_W = $bits(pinBundle_t);
endpackage

// ==== core/sync_2ff.sv ====
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: inputs are levels, bits are independent
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock, // destination clock
  input  wire logic             reset, // async reset, active high
  input  wire logic [WIDTH-1:0] d,     // asynchronous levels
  output logic      [WIDTH-1:0] q      // synchronised levels
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_check
    $error("sync_2ff needs WIDTH of at least 1");
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // sync_2ff

// ==== core/cfg_chain_link.sv ====
// Purpose: serial daisy-chain output on the configuration clock
// Assumes: byteIn stays stable between request and acknowledge toggles
// Notes: all logic runs on the falling configuration clock edge
`timescale 1ns/1ps
module cfg_chain_link import cfg_pkg::*; (
  input  wire logic              linkClock, // configuration clock pin
  input  wire logic              reset,     // async reset, active high
  input  wire logic [DATA_W-1:0] byteIn,    // byte held by system side
  input  wire logic              reqToggle, // new byte request
  output logic                   ackToggle, // byte fully shifted
  output logic                   chainOut   // serial data to downstream
);
  logic                 reqMeta_q;
  logic                 reqSync_q;
  logic                 reqSeen_q, reqSeen_d;
  logic [DATA_W-1:0]    shift_q, shift_d;
  logic [BIT_CNT_W-1:0] left_q, left_d;
  logic                 ack_d;
  logic                 out_d;

  always_comb begin
    reqSeen_d = reqSeen_q;
    shift_d   = shift_q;
    left_d    = left_q;
    ack_d     = ackToggle;
    out_d     = chainOut;
    if (left_q != '0) begin
      out_d   = shift_q[DATA_W-1];
      shift_d = {shift_q[DATA_W-2:0], 1'b0};
      left_d  = left_q - 1'b1;
      if (left_q == BIT_CNT_W'(1)) begin
        ack_d = !ackToggle;
      end
    end else if (reqSync_q != reqSeen_q) begin
      reqSeen_d = reqSync_q;
      out_d     = byteIn[DATA_W-1];
      shift_d   = {byteIn[DATA_W-2:0], 1'b0};
      left_d    = BITS_PER_BYTE - 1'b1;
    end
  end

  // output moves only on falling edges
  always_ff @(negedge linkClock or posedge reset) begin
    if (reset) begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
      reqSeen_q <= 1'b0;
      shift_q   <= '0;
      left_q    <= '0;
      ackToggle <= 1'b0;
      chainOut  <= 1'b0;
    end else begin
      reqMeta_q <= reqToggle;
      reqSync_q <= reqMeta_q;
      reqSeen_q <= reqSeen_d;
      shift_q   <= shift_d;
      left_q    <= left_d;
      ackToggle <= ack_d;
      chainOut  <= out_d;
    end
  end
endmodule // cfg_chain_link

// ==== core/cfg_port_pins.sv ====
// Purpose: configuration-time pin logic of a programmable device
// Assumes: pin inputs asynchronous to clock; cfgClock is the link clock
// Notes: external clocks sampled by edge detect, so must be slow
`timescale 1ns/1ps
module cfg_port_pins import cfg_pkg::*; #(
  parameter int CONFIG_BYTES = 1024,
  parameter int CLEAR_CYCLES = 64
) (
  input  wire logic              clock,         // system clock
  input  wire logic              reset,         // async reset, active high
  input  wire logic              cfgClock,      // configuration clock pin in
  input  wire logic              modeSelBit0,   // mode select bit 0
  input  wire logic              modeSelBit1,   // mode select bit 1
  input  wire logic              modeSelBit2,   // mode select bit 2
  input  wire logic              oscSpeedSel,   // oscillator speed select
  input  wire logic              scanSelect,    // boundary scan used
  input  wire logic [DELAY_W-1:0] doneDelaySel, // done release option
  input  wire logic [DELAY_W-1:0] pinDelaySel,  // pin release option
  input  wire logic              programN,      // restart, active low
  input  wire logic              initIn,        // hold line pin in
  input  wire hostCtl_t          hostCtl,       // host selects and strobes
  input  wire logic [DATA_W-1:0] dataIn,        // parallel data pins
  input  wire logic              serialIn,      // serial data pin
  output logic                   cfgClockOut,   // configuration clock out
  output logic                   cfgClockOe,    // configuration clock drive
  output logic                   initOut,       // hold line out, always low
  output logic                   initOe,        // hold line pull low
  output logic                   readyFlagBit,  // top data bit status
  output logic                   readyFlagOe,   // top data bit drive
  output logic                   readyOut,      // ready pin value
  output logic                   readyOe,       // ready pin drive
  output logic [ADDR_W-1:0]      addrOut,       // memory address
  output logic                   addrOe,        // address drive
  output logic                   chainOut,      // serial chain data
  output logic                   chainOe,       // serial chain drive
  output logic                   cfgBusyHigh,   // busy, active high
  output logic                   cfgBusyHighOe, // busy high drive
  output logic                   cfgBusyLowN,   // busy, active low
  output logic                   cfgBusyLowOe,  // busy low drive
  output logic                   doneOe,        // done pulled low
  output logic                   pullupEn,      // configuration pull-ups
  output logic                   testPinsUser   // test pins to user logic
);
  localparam logic [CNT_W-1:0]  CLEAR_LAST = CNT_W'(CLEAR_CYCLES - 1);
  localparam logic [ADDR_W-1:0] LAST_BYTES = ADDR_W'(CONFIG_BYTES);

  if (CONFIG_BYTES < 1 || CONFIG_BYTES >= (1 << ADDR_W) ||
      CLEAR_CYCLES < 1 || CLEAR_CYCLES >= (1 << CNT_W)) begin : g_check
    $error("cfg_port_pins parameter out of range");
  end

  pinBundle_t pins;
  logic       chainAck;

  sync_2ff #(.WIDTH(PIN_W)) u_sync (
    .clock (clock),
    .reset (reset),
    .d     ({initIn, programN, cfgClock, serialIn, hostCtl, oscSpeedSel,
             modeSelBit2, modeSelBit1, modeSelBit0, scanSelect,
             doneDelaySel, pinDelaySel, chainAck, dataIn}),
    .q     (pins)
  );

  cfgState_t            state_q, state_d;
  cfgMode_t             mode_q, mode_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic                 oscSlow_q, oscSlow_d;
  logic                 initPrev_q, clkPrev_q, wrPrev_q;
  logic [DIV_W-1:0]     divCnt_q, divCnt_d;
  logic [ADDR_W-1:0]    addr_q, addr_d;
  logic [ADDR_W-1:0]    byteCnt_q, byteCnt_d;
  logic [DATA_W-1:0]    shiftIn_q, shiftIn_d;
  logic [BIT_CNT_W-1:0] bitCnt_q, bitCnt_d;
  logic [DATA_W-1:0]    buf_q, buf_d;
  logic                 bufFull_q, bufFull_d;
  logic                 reqTog_q, reqTog_d;
  logic                 ackSeen_q, ackSeen_d;
  logic                 doneRel_q, doneRel_d;
  logic                 pinRel_q, pinRel_d;
  logic [DIV_W-1:0]     divLimit;
  logic                 intTick, extRise, wrFall, selected, driveClock;
  logic                 sampleEdge, newValid;
  logic [DATA_W-1:0]    newByte;

  cfg_chain_link u_link (
    .linkClock (cfgClock),
    .reset     (reset),
    .byteIn    (buf_q),
    .reqToggle (reqTog_q),
    .ackToggle (chainAck),
    .chainOut  (chainOut)
  );

  always_comb begin
    divLimit   = oscSlow_q ? SLOW_DIV : FAST_DIV;
    intTick    = (divCnt_q == divLimit - 1'b1);
    extRise    = pins.cfgClock && !clkPrev_q;
    wrFall     = wrPrev_q && !pins.host.loadStrobeN;
    selected   = !pins.host.chipSelLowN && pins.host.chipSelHigh;
    driveClock = mode_q inside {MODE_MASTER_SERIAL, MODE_MASTER_PARALLEL,
                                MODE_ASYNC_PERIPH};
    sampleEdge = driveClock ? intTick : extRise;
  end

  always_comb begin
    newValid  = 1'b0;
    newByte   = pins.data;
    shiftIn_d = shiftIn_q;
    bitCnt_d  = bitCnt_q;
    addr_d    = addr_q;
    if (state_q == ST_LOAD) begin
      unique case (mode_q)
        MODE_MASTER_SERIAL, MODE_SLAVE_SERIAL: begin
          if (sampleEdge && !bufFull_q) begin
            shiftIn_d = {shiftIn_q[DATA_W-2:0], pins.serialIn};
            bitCnt_d  = bitCnt_q + 1'b1;
            if (bitCnt_q == BITS_PER_BYTE - 1'b1) begin
              newValid = 1'b1;
              newByte  = shiftIn_d;
              bitCnt_d = '0;
            end
          end
        end
        MODE_MASTER_PARALLEL: begin
          if (sampleEdge && !bufFull_q) begin
            newValid = 1'b1;
            addr_d   = addr_q + 1'b1;
          end
        end
        MODE_SYNC_PERIPH: newValid = sampleEdge;
        MODE_SLAVE_PARALLEL: newValid = sampleEdge && selected &&
                                        !pins.host.loadStrobeN;
        MODE_ASYNC_PERIPH: newValid = selected && wrFall;
        MODE_RESERVED5, MODE_RESERVED6: newValid = 1'b0;
      endcase
    end else if (state_q == ST_WAIT) begin // restart fetches from address zero
      addr_d   = '0;
      bitCnt_d = '0;
    end
  end

  always_comb begin
    state_d   = state_q;
    mode_d    = mode_q;
    cnt_d     = cnt_q;
    oscSlow_d = oscSlow_q;
    divCnt_d  = intTick ? '0 : divCnt_q + 1'b1;
    byteCnt_d = byteCnt_q;
    buf_d     = buf_q;
    bufFull_d = bufFull_q;
    reqTog_d  = reqTog_q;
    ackSeen_d = ackSeen_q;
    doneRel_d = doneRel_q;
    pinRel_d  = pinRel_q;
    if (ackSeen_q != pins.chainAck) begin
      ackSeen_d = pins.chainAck;
      bufFull_d = 1'b0;
    end
    // a byte arriving while full is dropped
    if (newValid && !bufFull_q) begin
      buf_d     = newByte;
      bufFull_d = 1'b1;
      reqTog_d  = !reqTog_q;
      byteCnt_d = byteCnt_q + 1'b1;
    end
    unique case (state_q)
      ST_CLEAR: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CLEAR_LAST) begin
          state_d = ST_WAIT;
          cnt_d   = '0;
        end
      end
      ST_WAIT: begin
        if (pins.initLine && !initPrev_q) begin
          mode_d    = cfgMode_t'(pins.modeSel);
          oscSlow_d = pins.oscSpeedSel;
          byteCnt_d = '0;
          state_d   = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (byteCnt_q == LAST_BYTES && !bufFull_q) begin // last byte must leave the chain first
          state_d = ST_RELEASE;
          cnt_d   = '0;
        end
      end
      ST_RELEASE: begin
        if (intTick) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (cnt_q >= CNT_W'(pins.doneDelay)) begin
          doneRel_d = 1'b1;
        end
        if (cnt_q >= CNT_W'(pins.pinDelay)) begin
          pinRel_d = 1'b1;
        end
        if (doneRel_q && pinRel_q) begin
          state_d = ST_USER;
        end
      end
      ST_USER: state_d = ST_USER;
    endcase
    if (!pins.programN) begin
      state_d   = ST_CLEAR;
      cnt_d     = '0;
      doneRel_d = 1'b0;
      pinRel_d  = 1'b0;
    end
  end

  logic held, inLoad, drive_d, periph_d;
  always_comb begin
    held     = !pinRel_d;
    inLoad   = state_d inside {ST_LOAD, ST_RELEASE};
    drive_d  = mode_d inside {MODE_MASTER_SERIAL, MODE_MASTER_PARALLEL,
                              MODE_ASYNC_PERIPH};
    periph_d = mode_d inside {MODE_SYNC_PERIPH, MODE_ASYNC_PERIPH};
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q       <= ST_CLEAR;
      mode_q        <= MODE_MASTER_SERIAL;
      cnt_q         <= '0;
      oscSlow_q     <= 1'b0;
      initPrev_q    <= 1'b0;
      clkPrev_q     <= 1'b0;
      wrPrev_q      <= 1'b1;
      divCnt_q      <= '0;
      addr_q        <= '0;
      byteCnt_q     <= '0;
      shiftIn_q     <= '0;
      bitCnt_q      <= '0;
      buf_q         <= '0;
      bufFull_q     <= 1'b0;
      reqTog_q      <= 1'b0;
      ackSeen_q     <= 1'b0;
      doneRel_q     <= 1'b0;
      pinRel_q      <= 1'b0;
      cfgClockOut   <= 1'b0;
      cfgClockOe    <= 1'b0;
      initOut       <= 1'b0;
      initOe        <= 1'b1;
      readyFlagBit  <= 1'b0;
      readyFlagOe   <= 1'b0;
      readyOut      <= 1'b0;
      readyOe       <= 1'b0;
      addrOut       <= '0;
      addrOe        <= 1'b0;
      chainOe       <= 1'b0;
      cfgBusyHigh   <= 1'b1;
      cfgBusyHighOe <= 1'b1;
      cfgBusyLowN   <= 1'b0;
      cfgBusyLowOe  <= 1'b1;
      doneOe        <= 1'b1;
      pullupEn      <= 1'b1;
      testPinsUser  <= 1'b0;
    end else begin
      state_q       <= state_d;
      mode_q        <= mode_d;
      cnt_q         <= cnt_d;
      oscSlow_q     <= oscSlow_d;
      initPrev_q    <= pins.initLine;
      clkPrev_q     <= pins.cfgClock;
      wrPrev_q      <= pins.host.loadStrobeN;
      divCnt_q      <= divCnt_d;
      addr_q        <= addr_d;
      byteCnt_q     <= byteCnt_d;
      shiftIn_q     <= shiftIn_d;
      bitCnt_q      <= bitCnt_d;
      buf_q         <= buf_d;
      bufFull_q     <= bufFull_d;
      reqTog_q      <= reqTog_d;
      ackSeen_q     <= ackSeen_d;
      doneRel_q     <= doneRel_d;
      pinRel_q      <= pinRel_d;
      cfgClockOut   <= (divCnt_d < (divLimit >> 1));
      cfgClockOe    <= inLoad && drive_d && held;
      initOut       <= 1'b0;
      initOe        <= (state_d == ST_CLEAR);
      readyFlagBit  <= !bufFull_d;
      readyFlagOe   <= (state_d == ST_LOAD) && (mode_d == MODE_ASYNC_PERIPH) && selected &&
                       !pins.host.statusReadN && pins.host.loadStrobeN;
      readyOut      <= !bufFull_d && (state_d == ST_LOAD);
      readyOe       <= inLoad && periph_d && held;
      addrOut       <= addr_d;
      addrOe        <= inLoad && (mode_d == MODE_MASTER_PARALLEL) && held;
      chainOe       <= inLoad && held;
      cfgBusyHigh   <= held;
      cfgBusyHighOe <= held;
      cfgBusyLowN   <= !held;
      cfgBusyLowOe  <= held;
      doneOe        <= !doneRel_d;
      pullupEn      <= held;
      testPinsUser  <= (state_d == ST_USER) && !pins.scanSelect;
    end
  end

  a_mode_capture: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_WAIT && pins.initLine && !initPrev_q && pins.programN)
    |=> (state_q == ST_LOAD && mode_q == cfgMode_t'($past(pins.modeSel))))
    else $error("mode not latched on hold line rise");

  a_osc_capture: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_WAIT && pins.initLine && !initPrev_q && pins.programN)
    |=> (oscSlow_q == $past(pins.oscSpeedSel)) ##1 (divCnt_q < divLimit))
    else $error("oscillator speed not latched");

  a_scan_handover: assert property (@(posedge clock) disable iff (reset)
    testPinsUser |-> (state_q == ST_USER && pinRel_q && !cfgBusyHighOe))
    else $error("test pins released before configuration end");

  a_busy_high: assert property (@(posedge clock) disable iff (reset)
    (state_q inside {ST_CLEAR, ST_WAIT, ST_LOAD}) |-> (cfgBusyHigh && cfgBusyHighOe))
    else $error("busy high not driven while configuring");

  a_busy_low: assert property (@(posedge clock) disable iff (reset)
    (state_q inside {ST_CLEAR, ST_WAIT, ST_LOAD}) |-> (!cfgBusyLowN && cfgBusyLowOe))
    else $error("busy low not driven while configuring");

  a_hold_clear: assert property (@(posedge clock) disable iff (reset)
    $rose(state_q == ST_CLEAR) |-> initOe [*2])
    else $error("hold line not pulled low while clearing");

  a_wait_hold: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_WAIT && !pins.initLine) |=> (state_q != ST_LOAD))
    else $error("configuration began with hold line low");

  a_write_wins: assert property (@(posedge clock) disable iff (reset)
    (!pins.host.loadStrobeN && !pins.host.statusReadN) |=> !readyFlagOe)
    else $error("status driven during a load strobe");

  a_addr_step: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_LOAD && mode_q == MODE_MASTER_PARALLEL && sampleEdge && !bufFull_q && pins.programN)
    |=> (addr_q == $past(addr_q) + 1'b1) ##1 (addrOut == $past(addr_q)))
    else $error("master address did not advance");

  a_ready_flag: assert property (@(posedge clock) disable iff (reset)
    readyFlagOe |-> (readyFlagBit == !bufFull_q && readyOut == !bufFull_q))
    else $error("ready status disagrees with buffer");
endmodule // cfg_port_pins

// ==== bench/cfg_host_model.sv ====
// Purpose: host processor on the asynchronous peripheral port
// Assumes: requests change just after a rising clock edge
// Notes: released lines except chipSelHigh return to their pull-up level
`timescale 1ns/1ps
module cfg_host_model import cfg_pkg::*; (
  input  wire logic         clock,    // system clock
  input  wire logic         readyOut, // device ready pin
  output hostCtl_t          hostCtl,  // selects and strobes
  output logic [DATA_W-1:0] hostData, // data pins from host
  output logic              initRel   // hold line released by host
);
  localparam logic TestClkLevel = 1'b1;
  initial begin
    hostCtl = 4'hB;
    hostData = 8'hFF;
    initRel = 1'b0;
  end
  task automatic holdInit(input logic lvl);
    @(posedge clock);
    initRel <= lvl;
  endtask
  // selects and data settle before strobes, then stay held
  task automatic access(input logic [1:0] sel, input logic wrN, input logic rdN, input logic [7:0] d);
    @(posedge clock);
    hostData <= d;
    hostCtl <= {sel, 2'b11};
    repeat (3) @(posedge clock);
    hostCtl.loadStrobeN <= wrN;
    hostCtl.statusReadN <= rdN;
    repeat (4) @(posedge clock);
  endtask
  task automatic idle();
    @(posedge clock);
    hostCtl <= 4'hB;
    hostData <= 8'hFF;
    repeat (4) @(posedge clock);
  endtask
  task automatic waitReady();
    for (int k = 0; k < 300 && readyOut !== 1'b1; k++) @(posedge clock);
  endtask
endmodule // cfg_host_model

// ==== bench/tb.sv ====
// Purpose: self-checking bench for the configuration pin logic
// Assumes: asynchronous peripheral mode first, device drives its clock
// Notes: six bytes complete configuration
`timescale 1ns/1ps
module tb import cfg_pkg::*;;
  logic clock, reset, programN, oscSel, scanSel, cfgWire;
  logic [2:0] modeStrap;
  logic [1:0] doneSel, pinSel;
  hostCtl_t hostCtl;
  logic [7:0] hostData, chainBits;
  logic initRel, cfgClockOut, cfgClockOe, initOut, initOe, readyFlagBit, readyFlagOe, readyOut, readyOe;
  logic [ADDR_W-1:0] addrOut;
  logic addrOe, chainOut, chainOe, cfgBusyHigh, cfgBusyHighOe, cfgBusyLowN, cfgBusyLowOe, doneOe, pullupEn;
  logic testPinsUser;
  int numErrors = 0;
  int comparisons = 0;
  time t0;
  typedef struct packed { logic [7:0] data; logic [7:0] chainExp; } row_t;
  row_t rows [4] = '{'{8'hA5, 8'hA5}, '{8'h00, 8'h00}, '{8'hFF, 8'hFF}, '{8'h81, 8'h81}};
  assign cfgWire = cfgClockOe ? cfgClockOut : 1'b1;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  cfg_host_model host (.clock(clock), .readyOut(readyOut), .hostCtl(hostCtl), .hostData(hostData),
    .initRel(initRel));
  cfg_port_pins #(.CONFIG_BYTES(6), .CLEAR_CYCLES(4)) dut (.clock(clock), .reset(reset), .cfgClock(cfgWire),
    .modeSelBit0(modeStrap[0]), .modeSelBit1(modeStrap[1]), .modeSelBit2(modeStrap[2]), .oscSpeedSel(oscSel),
    .scanSelect(scanSel), .doneDelaySel(doneSel), .pinDelaySel(pinSel), .programN(programN),
    .initIn(initOe ? 1'b0 : initRel), .hostCtl(hostCtl), .serialIn(hostData[0]),
    .dataIn({readyFlagOe ? readyFlagBit : hostData[7], hostData[6:0]}), .cfgClockOut(cfgClockOut),
    .cfgClockOe(cfgClockOe), .initOut(initOut), .initOe(initOe), .readyFlagBit(readyFlagBit),
    .readyFlagOe(readyFlagOe), .readyOut(readyOut), .readyOe(readyOe), .addrOut(addrOut), .addrOe(addrOe),
    .chainOut(chainOut), .chainOe(chainOe), .cfgBusyHigh(cfgBusyHigh), .cfgBusyHighOe(cfgBusyHighOe),
    .cfgBusyLowN(cfgBusyLowN), .cfgBusyLowOe(cfgBusyLowOe), .doneOe(doneOe), .pullupEn(pullupEn),
    .testPinsUser(testPinsUser));
  // chain bits sampled one system clock after each falling edge
  always @(negedge cfgWire) begin
    @(posedge clock);
    chainBits <= {chainBits[6:0], chainOut};
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic period(input logic [DIV_W-1:0] exp);
    @(posedge cfgWire);
    t0 = $time;
    @(posedge cfgWire);
    check(18'(($time - t0) / 20), 18'(exp));
  endtask
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    numErrors++;
    completeRun();
  end
  initial begin
    reset = 1'b1;
    programN = 1'b1;
    oscSel = 1'b0;
    scanSel = 1'b0;
    modeStrap = 3'h4;
    doneSel = 2'h1;
    pinSel = 2'h2;
    repeat (8) @(posedge clock);
    check({initOe, cfgBusyHigh, cfgBusyLowN, doneOe, pullupEn}, 5'h1B);
    reset <= 1'b0;
    repeat (40) @(posedge clock);
    check({initOut, initOe, cfgClockOe, readyOe, cfgBusyHigh}, 5'h01);
    host.holdInit(1'b1);
    repeat (8) @(posedge clock);
    check({cfgClockOe, readyOe, addrOe, readyOut, chainOe}, 5'h1B);
    period(FAST_DIV);
    $display("test reset and mode latch done");
    foreach (rows[i]) begin
      host.access(2'b01, 1'b0, 1'b1, rows[i].data);
      check(readyOut, 1'b0);
      host.idle();
      host.waitReady();
      check(chainBits, rows[i].chainExp);
    end
    $display("test byte rows done");
    for (int s = 0; s < 3; s++) begin
      host.access(s == 0 ? 2'b00 : (s == 1 ? 2'b11 : 2'b10), 1'b0, 1'b1, 8'h3C);
      check(readyOut, 1'b1);
      host.idle();
    end
    host.access(2'b01, 1'b1, 1'b0, 8'hFF);
    check({readyFlagOe, readyFlagBit}, 2'b11);
    host.idle();
    host.access(2'b01, 1'b0, 1'b1, 8'h96);
    host.idle();
    host.access(2'b01, 1'b1, 1'b0, 8'hFF);
    check({readyFlagOe, readyFlagBit}, 2'b10);
    host.idle();
    host.access(2'b01, 1'b0, 1'b1, 8'h0F);
    host.idle();
    host.waitReady();
    check(chainBits, 8'h96);
    repeat (50) @(posedge clock);
    check(readyOut, 1'b1);
    check(chainBits, 8'h00);
    host.access(2'b01, 1'b0, 1'b0, 8'hC3);
    check({readyFlagOe, readyOut}, 2'b00);
    host.idle();
    host.waitReady();
    check(chainBits, 8'hC3);
    $display("test select and status done");
    for (int k = 0; k < 300 && doneOe !== 1'b0; k++) @(posedge clock);
    check({doneOe, pullupEn}, 2'b01);
    for (int k = 0; k < 300 && testPinsUser !== 1'b1; k++) @(posedge clock);
    check({cfgBusyHigh, cfgBusyHighOe, cfgBusyLowN, cfgBusyLowOe, pullupEn, cfgClockOe, readyOe, chainOe},
      8'h20);
    check(testPinsUser, 1'b1);
    $display("test release done");
    host.holdInit(1'b0);
    programN <= 1'b0;
    modeStrap <= 3'h2;
    oscSel <= 1'b1;
    scanSel <= 1'b1;
    doneSel <= 2'h0;
    repeat (10) @(posedge clock);
    programN <= 1'b1;
    repeat (40) @(posedge clock);
    check({cfgBusyHigh, addrOe, testPinsUser}, 3'h4);
    host.holdInit(1'b1);
    repeat (8) @(posedge clock);
    check({addrOe, readyOe, cfgClockOe}, 3'h5);
    period(SLOW_DIV);
    check(addrOut, 18'h1);
    $display("test restart done");
    completeRun();
  end
endmodule // tb
